/* File: hw/jlt_link_tx.sv */
// Serial link transmitter: start-up sequencing, fixed latencies and data path
//
// What this block does
// - Enable loads default 12-bit, four-per-lane, unscrambled configuration.
// - Lane rate equals 0.01 times F times fc.
// - Sync low gives K28.5 after 17 cycles.
// - Alignment K28.0 eleven cycles after LMFC boundary.
// - Sample octets reach lane after 14 cycles.
`timescale 1ns/1ns
module jlt_link_tx
  import jlt_pkg::*;
#(
  parameter int LMFC_FRAMES = 8,
  parameter int ILA_MULTIFRAMES = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic serial_link_enable_i,
  input wire logic sync_n_i,
  input wire logic sysref_i,
  input wire jlt_sample_type sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  output jlt_lane_type lane_o,
  output logic lane_valid_o,
  input wire logic lane_ready_i,
  output jlt_cfg_type cfg_o,
  output jlt_phase_type phase_o
);
  localparam logic [7:0] LMFC_LAST = 8'(LMFC_FRAMES - 1);
  localparam logic [2:0] MF_LAST = 3'(ILA_MULTIFRAMES - 1);

  typedef struct packed {
    jlt_phase_type phase;
    logic en_prev;
    logic sync_prev;
    logic [4:0] cnt;
    logic [7:0] lmfc;
    logic [7:0] frame;
    logic [2:0] mf;
    jlt_cfg_type cfg;
    logic [PIPE_STAGES-1:0] pv;
    logic [PIPE_STAGES-1:0][FRAME_W-1:0] pd;
    logic [1:0] bv;
    logic [1:0][FRAME_W-1:0] bd;
    jlt_lane_type lane;
    logic lane_v;
  } jlt_state_type;

  jlt_state_type st_reg;
  jlt_state_type st_next;
  logic pop;
  logic adv;
  logic seq_go;
  logic sync_fall;
  logic sync_rise;
  jlt_lane_type data_frame;

  // One ILA frame; first multiframe octet is K28.0, last is K28.3
  function automatic jlt_lane_type ila_frame(input logic [7:0] fr, input logic [2:0] m);
    ila_frame.octet = '0;
    ila_frame.k = '0;
    if (fr == 8'h00) begin
      ila_frame.octet[OCTETS-1] = K_MF_START;
      ila_frame.k[OCTETS-1] = 1'b1;
      if (m == 3'h1) begin
        ila_frame.octet[OCTETS-2] = K_CFG;
        ila_frame.k[OCTETS-2] = 1'b1;
      end
    end
    if (fr == LMFC_LAST) begin
      ila_frame.octet[0] = K_ALIGN;
      ila_frame.k[0] = 1'b1;
    end
  endfunction

  // Buffer head drains whenever the serializer is ready; outside idle, CGS wait, data phases and the last ILA frame the word is discarded
  assign pop = st_reg.bv[0] && lane_ready_i;
  // Pipeline stalls only when the two-entry buffer is full and not draining
  assign adv = !st_reg.bv[1] || pop;
  assign sample_ready_o = adv;
  // Sequencer holds while the serializer refuses the current frame
  assign seq_go = lane_ready_i || !st_reg.lane_v;
  assign sync_fall = st_reg.en_prev && st_reg.sync_prev && !sync_n_i;
  assign sync_rise = !st_reg.sync_prev && sync_n_i;
  assign data_frame = st_reg.bv[0] ? jlt_data_frame(st_reg.bd[0]) : jlt_data_frame('0);

  always_comb begin
    st_next = st_reg;
    st_next.en_prev = serial_link_enable_i;
    st_next.sync_prev = sync_n_i;
    // data pipeline: fixed stages plus buffer plus lane register
    if (adv) begin
      st_next.pv = {st_reg.pv[PIPE_STAGES-2:0], sample_valid_i};
      st_next.pd = {st_reg.pd[PIPE_STAGES-2:0], jlt_pack(sample_i)};
    end
    if (pop) begin
      st_next.bv = {1'b0, st_reg.bv[1]};
      st_next.bd[0] = st_reg.bd[1];
    end
    if (adv && st_reg.pv[PIPE_STAGES-1]) begin
      if (!st_next.bv[0]) begin
        st_next.bv[0] = 1'b1;
        st_next.bd[0] = st_reg.pd[PIPE_STAGES-1];
      end else begin
        st_next.bv[1] = 1'b1;
        st_next.bd[1] = st_reg.pd[PIPE_STAGES-1];
      end
    end
    // Local multiframe clock, realigned by the reference pulse
    if (sysref_i || st_reg.lmfc == LMFC_LAST) begin
      st_next.lmfc = 8'h00;
    end else begin
      st_next.lmfc = st_reg.lmfc + 8'h01;
    end
    if (!serial_link_enable_i) begin
      st_next.phase = PH_OFF;
      st_next.lane_v = 1'b0;
    end else if (!st_reg.en_prev) begin
      st_next.cfg = CFG_DEFAULT;
      st_next.phase = PH_IDLE;
    end else if (sync_fall) begin
      st_next.phase = PH_CGS_WAIT;
      st_next.cnt = CGS_LOAD;
    end else if (seq_go) begin
      // one full frame per device clock
      st_next.lane_v = 1'b1;
      st_next.lane = jlt_ctrl_frame(K_SYNC);
      st_next.cnt = st_reg.cnt - 5'h01;
      case (st_reg.phase)
        PH_CGS_WAIT: begin
          if (st_reg.cnt == 5'h01) begin
            st_next.phase = PH_CGS;
          end else begin
            st_next.lane = data_frame;
          end
        end
        PH_CGS: begin
          if (sync_rise) begin
            st_next.phase = PH_LMFC_WAIT;
          end
        end
        PH_LMFC_WAIT: begin
          if (st_reg.lmfc == 8'h00) begin
            st_next.phase = PH_ILA_WAIT;
            st_next.cnt = ILA_LOAD;
          end
        end
        PH_ILA_WAIT: begin
          if (st_reg.cnt == 5'h01) begin
            st_next.phase = PH_ILA;
            st_next.frame = 8'h00;
            st_next.mf = 3'h0;
            st_next.lane = ila_frame(8'h00, 3'h0);
          end
        end
        PH_ILA: begin
          if (st_reg.frame == LMFC_LAST) begin
            st_next.frame = 8'h00;
            st_next.mf = st_reg.mf + 3'h1;
          end else begin
            st_next.frame = st_reg.frame + 8'h01;
          end
          if (st_reg.frame == LMFC_LAST && st_reg.mf == MF_LAST) begin
            st_next.phase = PH_DATA;
            st_next.lane = data_frame;
          end else begin
            st_next.lane = ila_frame(st_next.frame, st_next.mf);
          end
        end
        default: begin
          st_next.lane = data_frame;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{phase: PH_OFF, sync_prev: 1'b1, cfg: CFG_RESET, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign lane_o = st_reg.lane;
  assign lane_valid_o = st_reg.lane_v;
  assign cfg_o = st_reg.cfg;
  assign phase_o = st_reg.phase;

  // Helper: consecutive cycles with the serializer ready, saturating
  logic [4:0] rdy_run;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdy_run <= '0;
    end else if (!lane_ready_i) begin
      rdy_run <= '0;
    end else if (rdy_run != 5'h1f) begin
      rdy_run <= rdy_run + 5'h01;
    end
  end

  sequence s_cgs_start;
    st_reg.phase == PH_CGS && $past(st_reg.phase) == PH_CGS_WAIT;
  endsequence

  sequence s_ila_start;
    st_reg.phase == PH_ILA && $past(st_reg.phase) == PH_ILA_WAIT;
  endsequence

  a_default_cfg: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    serial_link_enable_i && !st_reg.en_prev |=> cfg_o == CFG_DEFAULT && !cfg_o.scramble_en)
    else $error("Default configuration not loaded on enable");

  a_frame_rate: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $past(serial_link_enable_i) && serial_link_enable_i && phase_o != PH_IDLE
      |-> lane_valid_o)
    else $error("Lane missed a frame while enabled");

  a_cgs_latency: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_cgs_start |-> $past(sync_fall, 17) && lane_o == jlt_ctrl_frame(K_SYNC))
    else $error("K28.5 did not start 17 cycles after sync fell");

  a_ila_latency: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (s_ila_start and rdy_run > 5'd11) |-> $past(st_reg.phase, 11) == PH_LMFC_WAIT
      && $past(st_reg.phase, 10) == PH_ILA_WAIT
      && lane_o.octet[OCTETS-1] == K_MF_START && lane_o.k[OCTETS-1])
    else $error("ILA did not start 11 cycles after the LMFC boundary");

  a_data_latency: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    sample_valid_i && sample_ready_o && !st_reg.bv[0] && st_reg.phase == PH_DATA
      |-> ##14 (rdy_run < 5'd15 || phase_o != PH_DATA
      || lane_o.octet == $past(jlt_pack(sample_i), 14)))
    else $error("Sample octets not on lane 14 cycles later");
endmodule

/* File: shared/jlt_pkg.sv */
// Shared constants, types and helpers for the serial link start-up transmitter
package jlt_pkg;
  // Default link configuration loaded when the link is switched on
  localparam int RES_BITS = 12;
  localparam int SER_BITS = 12;
  localparam int CONV_PER_LANE = 4;
  localparam int OCT_W = 8;
  // Octets per frame: four 12-bit words fill six octets
  localparam int OCTETS = (CONV_PER_LANE * SER_BITS) / OCT_W;
  localparam int FRAME_W = OCTETS * OCT_W;
  // Device clock and resulting lane rate, 0.01 * F * fc Gbps in Mbps
  localparam int CLK_MHZ = 100;
  localparam int LANE_RATE_MBPS = 10 * OCTETS * CLK_MHZ;
  // Fixed latencies in device clock cycles
  localparam int CGS_DLY_CYC = 17;
  localparam int ILA_DLY_CYC = 11;
  localparam int DATA_LAT_CYC = 14;
  localparam int PIPE_STAGES = DATA_LAT_CYC - 2;
  localparam logic [4:0] CGS_LOAD = 5'(CGS_DLY_CYC - 1);
  localparam logic [4:0] ILA_LOAD = 5'(ILA_DLY_CYC - 1);
  // Control characters
  localparam logic [7:0] K_SYNC = 8'hbc;
  localparam logic [7:0] K_MF_START = 8'h1c;
  localparam logic [7:0] K_ALIGN = 8'h7c;
  localparam logic [7:0] K_CFG = 8'h9c;

  typedef enum logic [2:0] {
    PH_OFF, PH_IDLE, PH_CGS_WAIT, PH_CGS, PH_LMFC_WAIT, PH_ILA_WAIT, PH_ILA, PH_DATA
  } jlt_phase_type;

  typedef struct packed {
    logic [4:0] res_bits;
    logic [4:0] ser_bits;
    logic [2:0] conv_per_lane;
    logic scramble_en;
  } jlt_cfg_type;

  localparam jlt_cfg_type CFG_DEFAULT = '{
    res_bits: 5'(RES_BITS), ser_bits: 5'(SER_BITS),
    conv_per_lane: 3'(CONV_PER_LANE), scramble_en: 1'b0};
  localparam jlt_cfg_type CFG_RESET = '{default: '0};

  typedef struct packed {
    logic [CONV_PER_LANE-1:0][RES_BITS-1:0] conv;
  } jlt_sample_type;

  // Octet OCTETS-1 goes on the wire first
  typedef struct packed {
    logic [OCTETS-1:0][OCT_W-1:0] octet;
    logic [OCTETS-1:0] k;
  } jlt_lane_type;

  // Converter words packed MSB first into one frame, no scrambling
  function automatic logic [FRAME_W-1:0] jlt_pack(input jlt_sample_type s);
    jlt_pack = s.conv;
  endfunction

  function automatic jlt_lane_type jlt_data_frame(input logic [FRAME_W-1:0] d);
    jlt_data_frame.octet = d;
    jlt_data_frame.k = '0;
  endfunction

  function automatic jlt_lane_type jlt_ctrl_frame(input logic [OCT_W-1:0] c);
    jlt_ctrl_frame.octet = {OCTETS{c}};
    jlt_ctrl_frame.k = '1;
  endfunction
endpackage

/* File: testbench/jlt_rx_model.sv */
// Receiver-side partner: drives sync and sysref and can stall lane intake
`timescale 1ns/1ns
module jlt_rx_model
  import jlt_pkg::*;
(
  input wire logic clk_i,
  input wire logic resync_i,
  input wire logic stall_i,
  input wire jlt_lane_type lane_i,
  input wire logic lane_valid_i,
  output logic sync_n_o,
  output logic sysref_o,
  output logic lane_ready_o
);
  logic req;
  int lock_cnt = 0;
  initial begin
    sync_n_o = 1'b1;
    sysref_o = 1'b0;
  end
  assign lane_ready_o = !stall_i;
  // Latched on the rising edge so the bench and model never race
  always @(posedge clk_i) req <= resync_i;
  always @(negedge clk_i) begin
    sysref_o <= 1'b0;
    if (req) begin
      sync_n_o <= 1'b0;
      lock_cnt <= 0;
    end else if (!sync_n_o && lane_valid_i && lane_i.k === 6'h3f && lane_i.octet[0] === 8'hbc) begin
      lock_cnt <= lock_cnt + 1;
      if (lock_cnt == 3) begin
        sync_n_o <= 1'b1;
        sysref_o <= 1'b1;
      end
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the serial link start-up transmitter
`timescale 1ns/1ns
module tb_top import jlt_pkg::*;;
  logic clk, rst_n, en, sysref, sync_n, lane_ready, valid, sready, lvalid, resync, stall, low;
  jlt_sample_type sample;
  jlt_lane_type lane;
  jlt_cfg_type cfg;
  jlt_phase_type phase;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int t_fall, t_rise, c;
  logic [FRAME_W-1:0] exp_q[$];
  logic [FRAME_W-1:0] got_q[$];

  jlt_link_tx #(.LMFC_FRAMES(8), .ILA_MULTIFRAMES(4)) uut (.clk_i(clk), .rst_n_i(rst_n),
    .serial_link_enable_i(en), .sync_n_i(sync_n), .sysref_i(sysref), .sample_i(sample),
    .sample_valid_i(valid), .sample_ready_o(sready), .lane_o(lane), .lane_valid_o(lvalid),
    .lane_ready_i(lane_ready), .cfg_o(cfg), .phase_o(phase));
  jlt_rx_model rx (.clk_i(clk), .resync_i(resync), .stall_i(stall), .lane_i(lane),
    .lane_valid_i(lvalid), .sync_n_o(sync_n), .sysref_o(sysref), .lane_ready_o(lane_ready));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  always @(negedge sync_n) t_fall = cyc;
  always @(posedge sync_n) t_rise = cyc;
  always @(posedge clk) begin
    if (valid && sready) exp_q.push_back(sample.conv);
    if (lvalid && lane_ready && lane.k == 6'h00 && lane.octet != '0) got_q.push_back(lane.octet);
  end

  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_phase(input jlt_phase_type p);
    for (int i = 0; i < 80 && phase !== p; i++) @(negedge clk);
  endtask

  task automatic t_reset();
    check("valid_rst", 64'h0, lvalid);
    check("cfg_rst", 64'h0, cfg);
    check("phase_rst", PH_OFF, phase);
    check("ready_rst", 64'h1, sready);
    rst_n = 1'b1;
    @(negedge clk);
    // enable stands in for host setup
    en = 1'b1;
    @(negedge clk);
    check("cfg_default", {5'h0c, 5'h0c, 3'h4, 1'h0}, cfg);
    check("phase_idle", PH_IDLE, phase);
    check("lane_rate", 64'h1770, LANE_RATE_MBPS);
  endtask

  task automatic t_sync();
    resync = 1'b1;
    @(negedge clk);
    resync = 1'b0;
    wait_phase(PH_CGS);
    check("cgs_delay", 64'h11, cyc - t_fall);
    check("cgs_frame", {{6{8'hbc}}, 6'h3f}, lane);
    wait_phase(PH_ILA);
    check("ila_delay", 64'h0c, cyc - t_rise);
    check("ila_start", {8'h1c, 1'b1}, {lane.octet[5], lane.k[5]});
    wait_phase(PH_DATA);
    check("ila_length", 64'h2c, cyc - t_rise);
  endtask

  task automatic t_latency();
    sample.conv = 48'h123456789abc;
    valid = 1'b1;
    c = cyc;
    @(negedge clk);
    sample.conv = 48'hfedcba987654;
    @(negedge clk);
    valid = 1'b0;
    repeat (c + 14 - cyc) @(negedge clk);
    check("lat_first", 48'h123456789abc, lane.octet);
    @(negedge clk);
    check("lat_second", 48'hfedcba987654, lane.octet);
  endtask

  // Stalled receiver must fill the buffer without losing a word
  task automatic t_stall();
    repeat (20) @(negedge clk);
    exp_q.delete();
    got_q.delete();
    low = 1'b0;
    stall = 1'b1;
    valid = 1'b1;
    for (int i = 1; i <= 24; i++) begin
      sample.conv = {4{12'(i)}};
      if (!sready) low = 1'b1;
      @(negedge clk);
    end
    check("ready_low", 64'h1, low);
    valid = 1'b0;
    stall = 1'b0;
    repeat (40) @(negedge clk);
    check("word_count", exp_q.size(), got_q.size());
    for (int i = 0; i < exp_q.size(); i++) check("word", exp_q[i], got_q[i]);
  endtask

  // Link off drops the lane; a sync fall while off must not start a sequence
  task automatic t_disable();
    en = 1'b0;
    resync = 1'b1;
    @(negedge clk);
    resync = 1'b0;
    check("phase_off", PH_OFF, phase);
    check("valid_off", 64'h0, lvalid);
    repeat (3) @(negedge clk);
    en = 1'b1;
    repeat (20) @(negedge clk);
    check("cfg_reload", {5'h0c, 5'h0c, 3'h4, 1'h0}, cfg);
    check("fall_ignored", PH_IDLE, phase);
  endtask

  initial begin
    rst_n = 1'b0;
    en = 1'b0;
    valid = 1'b0;
    sample = '0;
    resync = 1'b0;
    stall = 1'b0;
    repeat (10) @(negedge clk);
    t_reset();
    t_sync();
    t_latency();
    t_stall();
    // Second start-up from the data phase: a new fall restarts the sequence
    t_sync();
    t_disable();
    finish_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    $display("ERROR watchdog expected finish seen timeout");
    finish_test();
  end
endmodule
